// file: logic/lcis_pkg.sv
// Constants, field layouts and carrier types for the logic cell input select stage.
//
// Functional notes
// - Mux 1 (select bits 2-0) picks pin A, system clock, secondary oscillator, low-power RC, reference clock, or capture outputs A, B, C.
// - On cell one, mux 2 (bits 6-4) picks pin B, cell two, comparator 1, UART1 transmit, ADC end of conversion, multi capture match; 101 and 111 are reserved.
// - On cell two, mux 2 codes 011 and 001 pick UART2 transmit and the cell one output instead.
// - On cell one, mux 3 (bits 10-8) picks pin A, own output, comparator 2, SPI1 SDO, UART1 receive, unit two output, unit two match, unit three match.
// - On cell two, mux 3 codes 100, 011 and 001 pick UART2 receive, SPI2 SDO and cell two's own output.
// - On cell one, mux 4 (bits 14-12) picks pin B, cell two, unit three output, SPI1 SDI, calendar event, multi capture match, unit three match; 100 is reserved.
// - On cell two, mux 4 codes 011 and 001 pick SPI2 SDI and the cell one output.
// - Unused select bits 31-15, 11, 7 and 3 read as zero and ignore writes.
// - The gate enable register holds one byte per gate, gate 4 at the top, each byte ordered source 4 down to 1 with true above negated.
// - A set true enable bit feeds the mux output into its gate; a clear bit keeps it out.
// - A set negated enable bit feeds the inverted mux output into its gate; a clear bit keeps it out.
// - Each gate result is inverted when its polarity bit is one and passed when zero.
// - Writes at register offset 0x4, 0x8 and 0xC clear, set and invert the bits written as one.
package lcis_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map: the register index sits in address bits 7-4.
  localparam logic [3:0]  REG_SEL = 4'h0;
  localparam logic [3:0]  REG_GLS = 4'h1;
  localparam logic [3:0]  REG_POL = 4'h2;

  // Access kind in address bits 3-2: offsets 0x0, 0x4, 0x8, 0xC.
  localparam logic [1:0]  OP_WRITE  = 2'h0;
  localparam logic [1:0]  OP_CLEAR  = 2'h1;
  localparam logic [1:0]  OP_SET    = 2'h2;
  localparam logic [1:0]  OP_INVERT = 2'h3;

  // Implemented bits and reset values.
  localparam logic [31:0] SEL_MASK  = 32'h0000_7777;
  localparam logic [31:0] GLS_MASK  = 32'hFFFF_FFFF;
  localparam logic [31:0] POL_MASK  = 32'h0000_000F;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] GLS_RESET = 32'h0000_0000;
  localparam logic [3:0]  POL_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Select field positions and gate enable layout.
  localparam int MUX1_LSB     = 0;
  localparam int MUX2_LSB     = 4;
  localparam int MUX3_LSB     = 8;
  localparam int MUX4_LSB     = 12;
  localparam int GATE_BYTE    = 8;
  localparam int TRUE_BIT_OFS = 1;
  localparam int NEG_BIT_OFS  = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Source codes per mux.
  localparam logic [2:0] M1_PIN_A    = 3'h0;
  localparam logic [2:0] M1_SYS_CLK  = 3'h1;
  localparam logic [2:0] M1_SEC_OSC  = 3'h2;
  localparam logic [2:0] M1_LP_RC    = 3'h3;
  localparam logic [2:0] M1_REF_CLK  = 3'h4;
  localparam logic [2:0] M1_MULTI_A  = 3'h5;
  localparam logic [2:0] M1_MULTI_B  = 3'h6;
  localparam logic [2:0] M1_MULTI_C  = 3'h7;
  localparam logic [2:0] M2_PIN_B    = 3'h0;
  localparam logic [2:0] M2_PEER     = 3'h1;
  localparam logic [2:0] M2_CMP1     = 3'h2;
  localparam logic [2:0] M2_UART_TX  = 3'h3;
  localparam logic [2:0] M2_ADC_EOC  = 3'h4;
  localparam logic [2:0] M2_RSVD_LO  = 3'h5;
  localparam logic [2:0] M2_MULTI_MT = 3'h6;
  localparam logic [2:0] M2_RSVD_HI  = 3'h7;
  localparam logic [2:0] M3_PIN_A    = 3'h0;
  localparam logic [2:0] M3_SELF     = 3'h1;
  localparam logic [2:0] M3_CMP2     = 3'h2;
  localparam logic [2:0] M3_SPI_SDO  = 3'h3;
  localparam logic [2:0] M3_UART_RX  = 3'h4;
  localparam logic [2:0] M3_SC2_OUT  = 3'h5;
  localparam logic [2:0] M3_SC2_MT   = 3'h6;
  localparam logic [2:0] M3_SC3_MT   = 3'h7;
  localparam logic [2:0] M4_PIN_B    = 3'h0;
  localparam logic [2:0] M4_PEER     = 3'h1;
  localparam logic [2:0] M4_SC3_OUT  = 3'h2;
  localparam logic [2:0] M4_SPI_SDI  = 3'h3;
  localparam logic [2:0] M4_RSVD     = 3'h4;
  localparam logic [2:0] M4_CAL_EVT  = 3'h5;
  localparam logic [2:0] M4_MULTI_MT = 3'h6;
  localparam logic [2:0] M4_SC3_MT   = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // Carrier types.
  typedef struct packed {
    logic pin_a;
    logic pin_b;
    logic sys_clk;
    logic sec_osc;
    logic lp_rc;
    logic ref_clk;
    logic multi_out_a;
    logic multi_out_b;
    logic multi_out_c;
    logic multi_match;
    logic cmp1_out;
    logic cmp2_out;
    logic uart1_tx;
    logic uart2_tx;
    logic uart1_rx;
    logic uart2_rx;
    logic spi1_sdo;
    logic spi2_sdo;
    logic spi1_sdi;
    logic spi2_sdi;
    logic adc_eoc;
    logic sc2_out;
    logic sc2_match;
    logic sc3_out;
    logic sc3_match;
    logic cal_event;
    logic cell_one_out;
    logic cell_two_out;
  } lcis_src_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lcis_bus_req_type;

  typedef struct packed {
    logic [31:0] sel;
    logic [31:0] gls;
    logic [3:0]  pol;
    logic [31:0] rdata;
    logic [3:0]  gate_out;
  } lcis_state_type;

endpackage

// file: logic/lcis_gate_combine.sv
// One gate: OR of enabled true and negated sources, then polarity inversion.
`timescale 1ns/10ps
module lcis_gate_combine (
  // Selected data sources
  input  wire logic [3:0] data_in,
  // Enable byte of this gate and its polarity control
  input  wire logic [7:0] enable_in,
  input  wire logic       invert_in,
  // Gate result
  output logic            result_out
);

  logic [3:0] term;

  // Each source contributes its true and its negated form when enabled.
  genvar s;
  generate
    for (s = 0; s < 4; s++) begin : g_term
      assign term[s] = (enable_in[2*s+lcis_pkg::TRUE_BIT_OFS] & data_in[s])
                     | (enable_in[2*s+lcis_pkg::NEG_BIT_OFS] & ~data_in[s]);
    end
  endgenerate

  // With no enables the OR is zero; polarity is applied last.
  assign result_out = (|term) ^ invert_in;

endmodule

// file: logic/lcis_input_select.sv
// Input selection stage of one logic cell: source muxes, gate enables and register port.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module lcis_input_select #(
  parameter bit IS_CELL_TWO = 1'b0
) (
  // Clock and reset
  input  wire logic                       clock_in,
  input  wire logic                       resetn_in,
  // Register port
  input  wire lcis_pkg::lcis_bus_req_type bus_req_in,
  output logic [31:0]                     read_data_out,
  // Candidate sources
  input  wire lcis_pkg::lcis_src_type     src_in,
  // Gate results toward the logic cell core
  output logic [3:0]                      gate_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  lcis_pkg::lcis_state_type state;
  lcis_pkg::lcis_state_type next_state;
  logic [3:0]               mux_data;
  logic [3:0]               gate_result;
  logic [3:0]               reg_idx;
  logic [1:0]               op;
  logic                     aligned;
  logic                     wr_sel;
  logic                     wr_gls;
  logic                     wr_pol;
  logic [31:0]              pol_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Applies a plain write, clear, set or invert access and keeps only real bits.
  function automatic logic [31:0] apply_op(input logic [31:0] cur,
                                           input logic [1:0]  kind,
                                           input logic [31:0] val,
                                           input logic [31:0] mask);
    logic [31:0] res;
    res = cur;
    unique case (kind)
      lcis_pkg::OP_WRITE:  res = val;
      lcis_pkg::OP_CLEAR:  res = cur & ~val;
      lcis_pkg::OP_SET:    res = cur | val;
      lcis_pkg::OP_INVERT: res = cur ^ val;
    endcase
    return res & mask;
  endfunction

  // Mux 1 is the same on both cells.
  function automatic logic pick_mux1(input logic [2:0] code, input lcis_pkg::lcis_src_type s);
    logic r;
    r = 1'b0;
    unique case (code)
      lcis_pkg::M1_PIN_A:   r = s.pin_a;
      lcis_pkg::M1_SYS_CLK: r = s.sys_clk;
      lcis_pkg::M1_SEC_OSC: r = s.sec_osc;
      lcis_pkg::M1_LP_RC:   r = s.lp_rc;
      lcis_pkg::M1_REF_CLK: r = s.ref_clk;
      lcis_pkg::M1_MULTI_A: r = s.multi_out_a;
      lcis_pkg::M1_MULTI_B: r = s.multi_out_b;
      lcis_pkg::M1_MULTI_C: r = s.multi_out_c;
    endcase
    return r;
  endfunction

  // Mux 2: peer cell and UART transmit depend on which cell this is.
  function automatic logic pick_mux2(input logic [2:0] code, input lcis_pkg::lcis_src_type s);
    logic r;
    r = 1'b0;
    unique case (code)
      lcis_pkg::M2_PIN_B:    r = s.pin_b;
      lcis_pkg::M2_PEER:     r = IS_CELL_TWO ? s.cell_one_out : s.cell_two_out;
      lcis_pkg::M2_CMP1:     r = s.cmp1_out;
      lcis_pkg::M2_UART_TX:  r = IS_CELL_TWO ? s.uart2_tx : s.uart1_tx;
      lcis_pkg::M2_ADC_EOC:  r = s.adc_eoc;
      lcis_pkg::M2_MULTI_MT: r = s.multi_match;
      lcis_pkg::M2_RSVD_LO:  r = 1'b0;
      lcis_pkg::M2_RSVD_HI:  r = 1'b0;
    endcase
    return r;
  endfunction

  // Mux 3: own output, SPI data out and UART receive depend on the cell.
  function automatic logic pick_mux3(input logic [2:0] code, input lcis_pkg::lcis_src_type s);
    logic r;
    r = 1'b0;
    unique case (code)
      lcis_pkg::M3_PIN_A:   r = s.pin_a;
      lcis_pkg::M3_SELF:    r = IS_CELL_TWO ? s.cell_two_out : s.cell_one_out;
      lcis_pkg::M3_CMP2:    r = s.cmp2_out;
      lcis_pkg::M3_SPI_SDO: r = IS_CELL_TWO ? s.spi2_sdo : s.spi1_sdo;
      lcis_pkg::M3_UART_RX: r = IS_CELL_TWO ? s.uart2_rx : s.uart1_rx;
      lcis_pkg::M3_SC2_OUT: r = s.sc2_out;
      lcis_pkg::M3_SC2_MT:  r = s.sc2_match;
      lcis_pkg::M3_SC3_MT:  r = s.sc3_match;
    endcase
    return r;
  endfunction

  // Mux 4: peer cell and SPI data in depend on the cell.
  function automatic logic pick_mux4(input logic [2:0] code, input lcis_pkg::lcis_src_type s);
    logic r;
    r = 1'b0;
    unique case (code)
      lcis_pkg::M4_PIN_B:    r = s.pin_b;
      lcis_pkg::M4_PEER:     r = IS_CELL_TWO ? s.cell_one_out : s.cell_two_out;
      lcis_pkg::M4_SC3_OUT:  r = s.sc3_out;
      lcis_pkg::M4_SPI_SDI:  r = IS_CELL_TWO ? s.spi2_sdi : s.spi1_sdi;
      lcis_pkg::M4_RSVD:     r = 1'b0;
      lcis_pkg::M4_CAL_EVT:  r = s.cal_event;
      lcis_pkg::M4_MULTI_MT: r = s.multi_match;
      lcis_pkg::M4_SC3_MT:   r = s.sc3_match;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode: index, access kind and word alignment.
  assign reg_idx = bus_req_in.addr[7:4];
  assign op      = bus_req_in.addr[3:2];
  assign aligned = (bus_req_in.addr[1:0] == 2'h0);
  assign wr_sel  = bus_req_in.wr && aligned && (reg_idx == lcis_pkg::REG_SEL);
  assign wr_gls  = bus_req_in.wr && aligned && (reg_idx == lcis_pkg::REG_GLS);
  assign wr_pol  = bus_req_in.wr && aligned && (reg_idx == lcis_pkg::REG_POL);

  ////////////////////////////////////////////////////////////////////////////////
  // Source muxes driven from the stored select fields.
  assign mux_data[0] = pick_mux1(state.sel[lcis_pkg::MUX1_LSB +: 3], src_in);
  assign mux_data[1] = pick_mux2(state.sel[lcis_pkg::MUX2_LSB +: 3], src_in);
  assign mux_data[2] = pick_mux3(state.sel[lcis_pkg::MUX3_LSB +: 3], src_in);
  assign mux_data[3] = pick_mux4(state.sel[lcis_pkg::MUX4_LSB +: 3], src_in);

  ////////////////////////////////////////////////////////////////////////////////
  // Four gates, each fed by its own byte of the enable register.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_gate
      lcis_gate_combine u_gate (
        .data_in    (mux_data),
        .enable_in  (state.gls[g*lcis_pkg::GATE_BYTE +: lcis_pkg::GATE_BYTE]),
        .invert_in  (state.pol[g]),
        .result_out (gate_result[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Polarity access is worked out on the full word; only the low four bits are real.
  assign pol_word = apply_op({28'h0000000, state.pol}, op, bus_req_in.wdata,
                             lcis_pkg::POL_MASK);

  // Next state: register accesses, read answer and registered gate results.
  always_comb begin
    next_state          = state;
    next_state.gate_out = gate_result;
    next_state.rdata    = 32'h0000_0000;
    // Writes use the alias offsets for clear, set and invert.
    if (wr_sel) begin
      next_state.sel = apply_op(state.sel, op, bus_req_in.wdata, lcis_pkg::SEL_MASK);
    end
    if (wr_gls) begin
      next_state.gls = apply_op(state.gls, op, bus_req_in.wdata, lcis_pkg::GLS_MASK);
    end
    if (wr_pol) begin
      next_state.pol = pol_word[3:0];
    end
    // Reads answer only at the base offset; aliases and holes read zero.
    if (bus_req_in.rd && aligned && op == lcis_pkg::OP_WRITE) begin
      unique case (reg_idx)
        lcis_pkg::REG_SEL: next_state.rdata = state.sel & lcis_pkg::SEL_MASK;
        lcis_pkg::REG_GLS: next_state.rdata = state.gls;
        lcis_pkg::REG_POL: next_state.rdata = {28'h0000000, state.pol};
        default:           next_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register with synchronous reset to the documented values.
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      state.sel      <= lcis_pkg::SEL_RESET;
      state.gls      <= lcis_pkg::GLS_RESET;
      state.pol      <= lcis_pkg::POL_RESET;
      state.rdata    <= 32'h0000_0000;
      state.gate_out <= 4'h0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from flip-flops.
  assign read_data_out = state.rdata;
  assign gate_out      = state.gate_out;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);

  // Register access sequences.
  sequence s_sel_clear;
    wr_sel && op == lcis_pkg::OP_CLEAR;
  endsequence

  sequence s_gls_set;
    wr_gls && op == lcis_pkg::OP_SET;
  endsequence

  sequence s_gls_invert;
    wr_gls && op == lcis_pkg::OP_INVERT;
  endsequence

  sequence s_sel_read;
    bus_req_in.rd && aligned && op == lcis_pkg::OP_WRITE && reg_idx == lcis_pkg::REG_SEL;
  endsequence

  a_mux1_sysclk :
    assert property (state.sel[2:0] == lcis_pkg::M1_SYS_CLK |-> mux_data[0] == src_in.sys_clk)
    else $error("mux 1 does not follow the system clock source");

  a_mux2_reserved :
    assert property ((state.sel[6:4] == lcis_pkg::M2_RSVD_LO
                      || state.sel[6:4] == lcis_pkg::M2_RSVD_HI) |-> !mux_data[1])
    else $error("reserved mux 2 code is not low");

  a_mux2_peer :
    assert property (state.sel[6:4] == lcis_pkg::M2_PEER |->
                     mux_data[1] == (IS_CELL_TWO ? src_in.cell_one_out : src_in.cell_two_out))
    else $error("mux 2 peer code picks the wrong cell");

  a_mux3_self :
    assert property (state.sel[10:8] == lcis_pkg::M3_SELF |->
                     mux_data[2] == (IS_CELL_TWO ? src_in.cell_two_out : src_in.cell_one_out))
    else $error("mux 3 own output code picks the wrong cell");

  a_mux3_uart_rx :
    assert property (state.sel[10:8] == lcis_pkg::M3_UART_RX |->
                     mux_data[2] == (IS_CELL_TWO ? src_in.uart2_rx : src_in.uart1_rx))
    else $error("mux 3 receive code picks the wrong UART");

  a_mux2_uart_tx :
    assert property (state.sel[6:4] == lcis_pkg::M2_UART_TX |->
                     mux_data[1] == (IS_CELL_TWO ? src_in.uart2_tx : src_in.uart1_tx))
    else $error("mux 2 transmit code picks the wrong UART");

  a_mux3_spi_sdo :
    assert property (state.sel[10:8] == lcis_pkg::M3_SPI_SDO |->
                     mux_data[2] == (IS_CELL_TWO ? src_in.spi2_sdo : src_in.spi1_sdo))
    else $error("mux 3 data out code picks the wrong SPI");

  a_mux4_peer :
    assert property (state.sel[14:12] == lcis_pkg::M4_PEER |->
                     mux_data[3] == (IS_CELL_TWO ? src_in.cell_one_out : src_in.cell_two_out))
    else $error("mux 4 peer code picks the wrong cell");

  a_mux4_unit_out :
    assert property (state.sel[14:12] == lcis_pkg::M4_SC3_OUT |-> mux_data[3] == src_in.sc3_out)
    else $error("mux 4 does not follow the unit three output");

  a_mux4_reserved :
    assert property (state.sel[14:12] == lcis_pkg::M4_RSVD |-> !mux_data[3])
    else $error("reserved mux 4 code is not low");

  a_mux4_spi_sdi :
    assert property (state.sel[14:12] == lcis_pkg::M4_SPI_SDI |->
                     mux_data[3] == (IS_CELL_TWO ? src_in.spi2_sdi : src_in.spi1_sdi))
    else $error("mux 4 data in code picks the wrong SPI");

  a_sel_unused_zero :
    assert property (s_sel_read |=> (read_data_out & ~lcis_pkg::SEL_MASK) == 32'h0000_0000)
    else $error("unused select bits read as one");

  a_gate_true_path :
    assert property (state.gls[15:8] == 8'h02 && !state.pol[1] |=>
                     gate_out[1] == $past(mux_data[0]))
    else $error("true enable does not pass source 1 into gate 2");

  a_gate_neg_path :
    assert property (state.gls[31:24] == 8'h40 && !state.pol[3] |=>
                     gate_out[3] == !$past(mux_data[3]))
    else $error("negated enable does not pass inverted source 4 into gate 4");

  a_gate_polarity :
    assert property (state.gls[7:0] == 8'h03 && state.pol[0] |=> !gate_out[0])
    else $error("polarity control does not invert the gate result");

  a_gate_empty_low :
    assert property (state.gls[23:16] == 8'h00 && !state.pol[2] |=> !gate_out[2])
    else $error("gate with no enables is not low");

  a_sel_clear_alias :
    assert property (s_sel_clear |=> state.sel == ($past(state.sel) & ~$past(bus_req_in.wdata)))
    else $error("clear alias does not clear the written bits");

  a_gls_set_alias :
    assert property (s_gls_set |=> state.gls == ($past(state.gls) | $past(bus_req_in.wdata)))
    else $error("set alias does not set the written bits");

  a_gls_inv_alias :
    assert property (s_gls_invert ##1 1'b1 |-> state.gls == ($past(state.gls) ^ $past(bus_req_in.wdata)))
    else $error("invert alias does not toggle the written bits");

  a_reset_clears :
    assert property (@(posedge clock_in) disable iff (!resetn_in)
                     $rose(resetn_in) |-> state.sel == 32'h0000_0000 && state.gls == 32'h0000_0000)
    else $error("select or enable register not zero after reset");

endmodule

// file: sim/lcis_src_model.sv
// Far side model: drives the candidate source levels seen by one cell.
`timescale 1ns/10ps
module lcis_src_model (
  // Pattern control from the bench
  input  wire logic [4:0]         index_in,
  input  wire logic               invert_in,
  // Candidate sources toward the cell
  output lcis_pkg::lcis_src_type  src_out
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [27:0] one_hot;

  // One source stands apart from all the others, so a wrong mux pick shows up.
  // An index above 27 leaves every source at the same level.
  assign one_hot = (index_in < 5'd28) ? (28'h0000001 << index_in) : 28'h0000000;
  assign src_out = lcis_pkg::lcis_src_type'(invert_in ? ~one_hot : one_hot);
endmodule

// file: sim/logic_cell_input_select_tb.sv
// Self-checking bench for both cell instances of the input select stage.
`timescale 1ns/10ps
module logic_cell_input_select_tb;
  ////////////////////////////////////////////////////////////////////////////////
  logic                       clock_in  = 1'b0;
  logic                       resetn_in = 1'b0;
  lcis_pkg::lcis_bus_req_type bus_req   = '0;
  logic [4:0]                 idx_one   = 5'h1F;
  logic [4:0]                 idx_two   = 5'h1F;
  logic                       pat_inv   = 1'b0;
  lcis_pkg::lcis_src_type     src_one;
  lcis_pkg::lcis_src_type     src_two;
  logic [31:0]                rd_one;
  logic [31:0]                rd_two;
  logic [3:0]                 gate_one;
  logic [3:0]                 gate_two;
  int                         bad_count = 0;
  int                         checks    = 0;
  logic                       v;
  logic                       e;

  // Bit position of the expected source per cell, mux and code; 31 marks a reserved code.
  localparam int SRC_TAB [2][4][8] = '{
    '{'{27, 25, 24, 23, 22, 21, 20, 19}, '{26, 0, 17, 15, 7, 31, 18, 31},
      '{27, 1, 16, 11, 13, 6, 5, 3},     '{26, 0, 4, 9, 31, 2, 18, 3}},
    '{'{27, 25, 24, 23, 22, 21, 20, 19}, '{26, 1, 17, 14, 7, 31, 18, 31},
      '{27, 0, 16, 10, 12, 6, 5, 3},     '{26, 1, 4, 8, 31, 2, 18, 3}}};

  // Clock at 250 MHz.
  always #2 clock_in = ~clock_in;

  ////////////////////////////////////////////////////////////////////////////////
  // Both cells share the register port; each has its own source model.
  lcis_src_model src_model_one (.index_in(idx_one), .invert_in(pat_inv), .src_out(src_one));
  lcis_src_model src_model_two (.index_in(idx_two), .invert_in(pat_inv), .src_out(src_two));

  lcis_input_select #(.IS_CELL_TWO(1'b0)) dut (
    .clock_in(clock_in), .resetn_in(resetn_in), .bus_req_in(bus_req),
    .read_data_out(rd_one), .src_in(src_one), .gate_out(gate_one));

  lcis_input_select #(.IS_CELL_TWO(1'b1)) dut_two (
    .clock_in(clock_in), .resetn_in(resetn_in), .bus_req_in(bus_req),
    .read_data_out(rd_two), .src_in(src_two), .gate_out(gate_two));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic test_done();
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compare tasks, one for read data and one for gate results.
  task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check4(input string name, input logic [3:0] exp, input logic [3:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One strobed cycle on the register port, then back to idle.
  task automatic bus_cycle(input logic [7:0] addr, input logic [31:0] data, input logic rd);
    @(posedge clock_in);
    bus_req <= '{addr: addr, wdata: data, wr: ~rd, rd: rd};
    @(posedge clock_in);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
    bus_cycle(addr, data, 1'b0);
  endtask

  // Read data stand only in the cycle after the read strobe.
  task automatic reg_read(input logic [7:0] addr, input logic [31:0] exp);
    bus_cycle(addr, 32'h0000_0000, 1'b1);
    #1;
    check32("read_data_one", exp, rd_one);
    check32("read_data_two", exp, rd_two);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // A hang is cut short and counted.
  initial begin
    #40000;
    bad_count++;
    test_done();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    @(posedge clock_in);
    #1;
    check4("gate_one", 4'h0, gate_one);
    reg_read(8'h00, 32'h0000_0000);
    reg_read(8'h10, 32'h0000_0000);
    reg_read(8'h20, 32'h0000_0000);
    reg_write(8'h28, 32'h0000_0003);
    reg_read(8'h20, 32'h0000_0003);
    reg_write(8'h00, 32'hFFFF_FFFF);
    reg_read(8'h00, 32'h0000_7777);
    reg_write(8'h04, 32'h0000_0707);
    reg_read(8'h00, 32'h0000_7070);
    reg_write(8'h10, 32'hF0F0_F0F0);
    reg_write(8'h18, 32'h0000_00FF);
    reg_write(8'h14, 32'hF000_0000);
    reg_write(8'h1C, 32'h0000_FF00);
    reg_read(8'h10, 32'h00F0_0FFF);
    reg_read(8'h14, 32'h0000_0000);
    reg_read(8'h30, 32'h0000_0000);
    reg_read(8'h01, 32'h0000_0000);
    // Every code of every mux, with true and negated enables into all four gates.
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 8; c++) begin
        for (int k = 0; k < 2; k++) begin
          reg_write(8'h00, 32'(c) << (4 * m));
          reg_write(8'h10, 32'h0101_0101 << (2 * m + 1 - k));
          reg_write(8'h20, 32'(c));
          for (int p = 0; p < 2; p++) begin
            @(posedge clock_in);
            idx_one <= 5'(SRC_TAB[0][m][c]);
            idx_two <= 5'(SRC_TAB[1][m][c]);
            pat_inv <= p[0];
            repeat (2) @(posedge clock_in);
            #1;
            v = (SRC_TAB[0][m][c] < 28) ? ~p[0] : 1'b0;
            e = (k == 0) ? v : ~v;
            check4("gate_one", {4{e}} ^ 4'(c), gate_one);
            v = (SRC_TAB[1][m][c] < 28) ? ~p[0] : 1'b0;
            e = (k == 0) ? v : ~v;
            check4("gate_two", {4{e}} ^ 4'(c), gate_two);
          end
        end
      end
    end
    // A gate with nothing enabled gives zero before its polarity control.
    reg_write(8'h10, 32'h0000_0000);
    reg_write(8'h20, 32'h0000_0005);
    repeat (2) @(posedge clock_in);
    #1;
    check4("gate_one", 4'h5, gate_one);
    // Source 1 true and negated into gate 1 makes it high, then its polarity bit inverts it.
    reg_write(8'h10, 32'h0000_0003);
    repeat (2) @(posedge clock_in);
    #1;
    check4("gate_one", 4'h4, gate_one);
    check4("gate_two", 4'h4, gate_two);
    test_done();
  end
endmodule
